// File: rpps_page_regs.sv
// rpps_page_regs: per-source page selection and per-port link/embedded settings.
// assumes requests arrive as single-cycle strobes from the local i2c and back channel targets,
// and that the four port register blocks present data of req_in.addr combinationally.
//
// Contract
// - accesses to 0x4d-0x7f and 0xd0-0xdf go to selected port blocks.
// - paged reads return the one port chosen by read-port field bits 5:4.
// - paged writes reach every port whose write-enable bit 3..0 is set.
// - read port defaults to 0 locally, to carrying port over back channel.
// - back channel: write-enable bit of carrying port defaults to 1.
// - physical port field reads 0 locally, carrying port over back channel.
// - each access source keeps its own page selection state.
// - raw mode: embedded count 0 means all video, 1-3 first packets embedded.
// - embedded type field, reset 0x12, replaces raw type on first lines.
// - embedded settings have no effect in csi-2 receive mode.
// - bit 4 enables encoder crc error flagging.
// - status register port field shows the selected read port.
`timescale 1ns/1ps
module rpps_page_regs (
  input  wire logic                  core_clk_in,
  input  wire logic                  rst_in,
  input  wire logic                  req_valid_in,
  input  wire rpps_pkg::rpps_req_t   req_in,
  input  wire logic [3:0][7:0]       paged_rd_data_in,
  input  wire logic [3:0]            enc_crc_err_in,
  input  wire logic [3:0]            csi2_mode_in,
  input  wire logic [3:0]            frame_start_in,
  input  wire logic [3:0]            long_pkt_in,
  input  wire logic [3:0][5:0]       raw_type_in,
  output logic                       ack_out,
  output logic      [7:0]            rd_data_out,
  output logic      [3:0]            paged_wr_en_out,
  output logic      [7:0]            paged_addr_out,
  output logic      [7:0]            paged_wdata_out,
  output logic      [3:0]            crc_flag_out,
  output logic      [3:0][5:0]       dtype_out,
  output logic      [3:0]            embedded_out
);
  logic [1:0] rd_port_ff [rpps_pkg::NUM_SRCS];
  logic [3:0] wr_en_ff   [rpps_pkg::NUM_SRCS];
  logic [3:0] crc_cap_ff;
  logic [7:0] emb_ff     [rpps_pkg::NUM_PORTS];
  logic       src_ok;
  logic       is_bc;
  logic [1:0] cur_rd_port;
  logic [3:0] cur_wr_en;
  logic [1:0] phys_port;
  logic [7:0] sel_ext;
  logic [7:0] nxt_rd_data;

  // true for offsets served by the external port blocks
  function automatic logic is_paged_ext(input logic [7:0] a);
    is_paged_ext = (a >= rpps_pkg::OFS_PAGED_A_LO && a <= rpps_pkg::OFS_PAGED_A_HI) ||
                   (a >= rpps_pkg::OFS_PAGED_B_LO && a <= rpps_pkg::OFS_PAGED_B_HI);
  endfunction

  // page reset value of a source: local sources zero, back channel owns its own port
  function automatic logic [5:0] page_default(input int s);
    logic [1:0] p;
    p = 2'(s - int'(rpps_pkg::SRC_BC_BASE));
    if (s < int'(rpps_pkg::SRC_BC_BASE)) begin
      page_default = rpps_pkg::RST_PAGE_SELECT[5:0];
    end else begin
      page_default = {p, 4'(4'h1 << p)};
    end
  endfunction

  // decode of the requesting source; codes 6 and 7 are not answered
  assign src_ok      = req_in.src < 3'(rpps_pkg::NUM_SRCS);
  assign is_bc       = req_in.src >= rpps_pkg::SRC_BC_BASE;
  assign cur_rd_port = src_ok ? rd_port_ff[req_in.src] : 2'h0;
  assign cur_wr_en   = src_ok ? wr_en_ff[req_in.src] : 4'h0;
  assign phys_port   = is_bc ? 2'(req_in.src - rpps_pkg::SRC_BC_BASE) : 2'h0;
  assign sel_ext     = paged_rd_data_in[cur_rd_port];

  // read data mux; reserved bits are zero
  always_comb begin
    nxt_rd_data = 8'h00;
    case (req_in.addr)
      rpps_pkg::OFS_PAGE_SELECT:
        nxt_rd_data = {phys_port, cur_rd_port, cur_wr_en};
      rpps_pkg::OFS_LINK_CRC_CAP:
        nxt_rd_data = 8'(crc_cap_ff[cur_rd_port]) << rpps_pkg::POS_ENC_CRC_FLAG;
      rpps_pkg::OFS_RAW_EMB_TYPE:
        nxt_rd_data = emb_ff[cur_rd_port];
      rpps_pkg::OFS_PORT_STATUS:
        nxt_rd_data = {cur_rd_port, sel_ext[5:0]};
      default:
        nxt_rd_data = is_paged_ext(req_in.addr) ? sel_ext : 8'h00;
    endcase
  end

  // per-source page state: a source only ever touches its own slot
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int s = 0; s < rpps_pkg::NUM_SRCS; s++) begin
        {rd_port_ff[s], wr_en_ff[s]} <= page_default(s);
      end
    end else if (req_valid_in && src_ok && req_in.write &&
                 req_in.addr == rpps_pkg::OFS_PAGE_SELECT) begin
      rd_port_ff[req_in.src] <= req_in.wdata[5:4];
      wr_en_ff[req_in.src]   <= req_in.wdata[3:0];
    end
  end

  // per-port settings held here, written through the write enables
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      crc_cap_ff <= {4{rpps_pkg::RST_LINK_CRC_CAP[rpps_pkg::POS_ENC_CRC_FLAG]}};
      for (int p = 0; p < rpps_pkg::NUM_PORTS; p++) begin
        emb_ff[p] <= rpps_pkg::RST_RAW_EMB_TYPE;
      end
    end else if (req_valid_in && src_ok && req_in.write) begin
      for (int p = 0; p < rpps_pkg::NUM_PORTS; p++) begin
        if (cur_wr_en[p] && req_in.addr == rpps_pkg::OFS_LINK_CRC_CAP) begin
          crc_cap_ff[p] <= req_in.wdata[rpps_pkg::POS_ENC_CRC_FLAG];
        end
        if (cur_wr_en[p] && req_in.addr == rpps_pkg::OFS_RAW_EMB_TYPE) begin
          emb_ff[p] <= req_in.wdata;
        end
      end
    end
  end

  // answer and paged write strobes, one cycle after the request
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_out         <= 1'b0;
      rd_data_out     <= 8'h00;
      paged_wr_en_out <= 4'h0;
      paged_addr_out  <= 8'h00;
      paged_wdata_out <= 8'h00;
    end else begin
      ack_out         <= req_valid_in && src_ok;
      paged_wr_en_out <= (req_valid_in && src_ok && req_in.write && is_paged_ext(req_in.addr))
                         ? cur_wr_en : 4'h0;
      if (req_valid_in && src_ok) begin
        paged_addr_out  <= req_in.addr;
        paged_wdata_out <= req_in.wdata;
        if (!req_in.write) begin
          rd_data_out <= nxt_rd_data;
        end
      end
    end
  end

  // encoder crc errors flagged only where enabled; a clear enable bit simply stops the input
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      crc_flag_out <= 4'h0;
    end else begin
      crc_flag_out <= enc_crc_err_in & crc_cap_ff;
    end
  end

  // one packet typer per receive port
  for (genvar p = 0; p < rpps_pkg::NUM_PORTS; p++) begin : g_port
    rpps_pkt_typer u_typer (
      .core_clk_in    (core_clk_in),
      .rst_in         (rst_in),
      .frame_start_in (frame_start_in[p]),
      .long_pkt_in    (long_pkt_in[p]),
      .csi2_mode_in   (csi2_mode_in[p]),
      .lines_count_in (emb_ff[p][7:6]),
      .embed_type_in  (emb_ff[p][5:0]),
      .raw_type_in    (raw_type_in[p]),
      .dtype_out      (dtype_out[p]),
      .embedded_out   (embedded_out[p])
    );
  end

  AST_LOCAL_PHYS_ZERO: assert property (@(posedge core_clk_in) disable iff (rst_in)
    req_valid_in && !req_in.write && req_in.src < 3'h2 && req_in.addr == 8'h4c
    |=> ack_out && rd_data_out[7:6] == 2'h0)
    else $error("local read of page select shows nonzero physical port");

  AST_BC_PHYS_PORT: assert property (@(posedge core_clk_in) disable iff (rst_in)
    req_valid_in && !req_in.write && req_in.src >= 3'h2 && req_in.src <= 3'h5 && req_in.addr == 8'h4c
    |=> rd_data_out[7:6] == 2'($past(req_in.src) - 3'h2))
    else $error("back channel read of page select shows wrong physical port");

  AST_PAGED_WRITE: assert property (@(posedge core_clk_in) disable iff (rst_in)
    req_valid_in && src_ok && req_in.write && is_paged_ext(req_in.addr)
    |=> paged_wr_en_out == $past(cur_wr_en) && paged_wdata_out == $past(req_in.wdata))
    else $error("paged write strobes differ from write enables");

  AST_NO_STRAY_WRITE: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !(req_valid_in && req_in.write && is_paged_ext(req_in.addr)) |=> paged_wr_en_out == 4'h0)
    else $error("paged write strobe outside paged range");

  AST_PAGED_READ: assert property (@(posedge core_clk_in) disable iff (rst_in)
    req_valid_in && src_ok && !req_in.write && is_paged_ext(req_in.addr) && req_in.addr != 8'h4d
    |=> rd_data_out == $past(paged_rd_data_in[cur_rd_port]))
    else $error("paged read not from selected port");

  AST_STATUS_PORT: assert property (@(posedge core_clk_in) disable iff (rst_in)
    req_valid_in && src_ok && !req_in.write && req_in.addr == 8'h4d
    |=> rd_data_out[7:6] == $past(cur_rd_port))
    else $error("status port number differs from read port");

  AST_CAP_RESERVED: assert property (@(posedge core_clk_in) disable iff (rst_in)
    req_valid_in && src_ok && !req_in.write && req_in.addr == 8'h4a
    |=> rd_data_out[7:5] == 3'h0 && rd_data_out[3:0] == 4'h0)
    else $error("reserved bits of crc capability read nonzero");

  AST_SOURCE_ISOLATION: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !(req_valid_in && req_in.write && req_in.addr == 8'h4c && req_in.src == 3'h0)
    |=> $stable(rd_port_ff[0]) && $stable(wr_en_ff[0]))
    else $error("local source page changed by another source");

  AST_CRC_GATE: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ##1 crc_flag_out == ($past(enc_crc_err_in) & $past(crc_cap_ff)))
    else $error("crc flag not gated by enable");

  // refused source codes must leave no trace on the port blocks or the answer
  AST_REFUSED_SOURCE: assert property (@(posedge core_clk_in) disable iff (rst_in)
    req_valid_in && !src_ok |=> !ack_out && paged_wr_en_out == 4'h0)
    else $error("request from unknown source answered");

  // a back channel slot keeps its page while other sources rewrite theirs
  AST_BC_ISOLATION: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !(req_valid_in && req_in.write && req_in.addr == rpps_pkg::OFS_PAGE_SELECT && req_in.src == 3'h5)
    |=> $stable(rd_port_ff[5]) && $stable(wr_en_ff[5]))
    else $error("back channel source page changed by another source");

  // read data holds through writes and idle cycles, so a slow host still sees its byte
  AST_RD_HOLD: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !(req_valid_in && src_ok && !req_in.write) |=> $stable(rd_data_out))
    else $error("read data changed without a read");
endmodule // rpps_page_regs

// File: rpps_pkg.sv
// rpps_pkg: constants and carrier types for the rx port page select register logic.
// assumes one 20 MHz clock and a register access port fed by the i2c / back channel targets.
package rpps_pkg;
  localparam int unsigned NUM_PORTS = 4;
  localparam int unsigned NUM_SRCS  = 6;        // local i2c 0, local i2c 1, back channel of ports 0..3
  localparam logic [2:0]  SRC_BC_BASE = 3'h2;   // first back channel source code

  // register offsets
  localparam logic [7:0] OFS_LINK_CRC_CAP  = 8'h4a;
  localparam logic [7:0] OFS_RAW_EMB_TYPE  = 8'h4b;
  localparam logic [7:0] OFS_PAGE_SELECT   = 8'h4c;
  localparam logic [7:0] OFS_PORT_STATUS   = 8'h4d;
  localparam logic [7:0] OFS_PAGED_A_LO    = 8'h4d;
  localparam logic [7:0] OFS_PAGED_A_HI    = 8'h7f;
  localparam logic [7:0] OFS_PAGED_B_LO    = 8'hd0;
  localparam logic [7:0] OFS_PAGED_B_HI    = 8'hdf;

  // field positions
  localparam int unsigned POS_ENC_CRC_FLAG = 4;
  localparam int unsigned POS_PHYS_LO      = 6;
  localparam int unsigned POS_RDPORT_LO    = 4;
  localparam int unsigned POS_EMB_LINES_LO = 6;

  // reset values
  localparam logic [7:0] RST_LINK_CRC_CAP = 8'h00;
  localparam logic [7:0] RST_RAW_EMB_TYPE = 8'h12;
  localparam logic [7:0] RST_PAGE_SELECT  = 8'h00;

  // one register access, as handed over by an i2c or back channel target
  typedef struct packed {
    logic       write;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [2:0] src;
  } rpps_req_t;
endpackage

// File: rpps_pkt_typer.sv
// rpps_pkt_typer: data type choice for long packets of one receive port.
// assumes frame start and long packet strobes are one-cycle pulses synchronous to core_clk_in.
`timescale 1ns/1ps
module rpps_pkt_typer (
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  input  wire logic       frame_start_in,
  input  wire logic       long_pkt_in,
  input  wire logic       csi2_mode_in,
  input  wire logic [1:0] lines_count_in,
  input  wire logic [5:0] embed_type_in,
  input  wire logic [5:0] raw_type_in,
  output logic      [5:0] dtype_out,
  output logic            embedded_out
);
  logic [1:0] pkt_cnt_ff;
  logic       use_embed;

  // first n long packets of a frame are embedded data, only in raw mode
  assign use_embed = !csi2_mode_in && (pkt_cnt_ff < lines_count_in);

  // packet counter saturates at 3, which is the largest embedded line count
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pkt_cnt_ff <= 2'h0;
    end else if (frame_start_in) begin
      pkt_cnt_ff <= 2'h0;
    end else if (long_pkt_in && pkt_cnt_ff != 2'h3) begin
      pkt_cnt_ff <= pkt_cnt_ff + 2'h1;
    end
  end

  // type code latched per long packet
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      dtype_out    <= 6'h00;
      embedded_out <= 1'b0;
    end else if (long_pkt_in) begin
      dtype_out    <= use_embed ? embed_type_in : raw_type_in;
      embedded_out <= use_embed;
    end
  end

  AST_CSI2_NO_EMBED: assert property (@(posedge core_clk_in) disable iff (rst_in)
    long_pkt_in && csi2_mode_in |=> !embedded_out && dtype_out == $past(raw_type_in))
    else $error("embedded type used in csi-2 mode");

  AST_EMBED_TYPE: assert property (@(posedge core_clk_in) disable iff (rst_in)
    long_pkt_in && !frame_start_in && !csi2_mode_in && pkt_cnt_ff == 2'h0 && lines_count_in != 2'h0
    |=> embedded_out && dtype_out == $past(embed_type_in))
    else $error("first long packet not typed as embedded data");
endmodule // rpps_pkt_typer

// File: rpps_port_model.sv
// rpps_port_model: behavioural stand-in for the four receive port register blocks.
// assumes the read address is the request address, answered in the same cycle.
`timescale 1ns/1ps
module rpps_port_model (
  input  wire logic            core_clk_in,
  input  wire logic [3:0]      wr_en_in,
  input  wire logic [7:0]      wr_addr_in,
  input  wire logic [7:0]      wr_data_in,
  input  wire logic [7:0]      rd_addr_in,
  output logic      [3:0][7:0] rd_data_out
);
  logic [7:0] mem_ff [4][256];

  // port number in the top bits so a read from the wrong block shows at once
  initial begin
    for (int p = 0; p < 4; p++) begin
      for (int a = 0; a < 256; a++) begin
        mem_ff[p][a] = {p[1:0], a[5:0]};
      end
    end
  end

  // each block takes the byte only when its own strobe is up
  always @(posedge core_clk_in) begin
    for (int p = 0; p < 4; p++) begin
      if (wr_en_in[p]) begin
        mem_ff[p][wr_addr_in] <= wr_data_in;
      end
    end
  end

  // read data follows the address with no delay
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      rd_data_out[p] = mem_ff[p][rd_addr_in];
    end
  end
endmodule // rpps_port_model

// File: rx_port_page_select_tb_top.sv
// rx_port_page_select_tb_top: self-checking bench for rpps_page_regs.
// assumes the port model answers paged reads; inputs change on the falling edge.
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module rx_port_page_select_tb_top;
  typedef struct packed {
    logic       w;
    logic [7:0] a;
    logic [7:0] d;
    logic [2:0] s;
    logic       k;
    logic [7:0] rd;
    logic [3:0] we;
  } rpps_row_t;
  localparam int NROWS = 34;
  logic                core_clk_in;
  logic                rst_in;
  logic                req_valid_in;
  rpps_pkg::rpps_req_t req_in;
  logic [3:0][7:0]     paged_rd_data_in;
  logic [3:0]          enc_crc_err_in;
  logic [3:0]          csi2_mode_in;
  logic [3:0]          frame_start_in;
  logic [3:0]          long_pkt_in;
  logic [3:0][5:0]     raw_type_in;
  logic                ack_out;
  logic [7:0]          rd_data_out;
  logic [3:0]          paged_wr_en_out;
  logic [7:0]          paged_addr_out;
  logic [7:0]          paged_wdata_out;
  logic [3:0]          crc_flag_out;
  logic [3:0][5:0]     dtype_out;
  logic [3:0]          embedded_out;
  int                  mismatches = 0;
  int                  compares = 0;
  // write, addr, data, source, acked, read data, port strobes
  rpps_row_t rows [NROWS] = '{
    '{0, 8'h4c, 8'h00, 3'h0, 1, 8'h00, 4'h0},
    '{0, 8'h4c, 8'h00, 3'h3, 1, 8'h52, 4'h0},
    '{0, 8'h4c, 8'h00, 3'h5, 1, 8'hf8, 4'h0},
    '{0, 8'h50, 8'h00, 3'h0, 1, 8'h10, 4'h0},
    '{1, 8'h4c, 8'he5, 3'h0, 1, 8'h00, 4'h0},
    '{0, 8'h4c, 8'h00, 3'h0, 1, 8'h25, 4'h0},
    '{0, 8'h4c, 8'h00, 3'h3, 1, 8'h52, 4'h0},
    '{1, 8'h4c, 8'h31, 3'h4, 1, 8'h00, 4'h0},
    '{0, 8'h4c, 8'h00, 3'h4, 1, 8'hb1, 4'h0},
    '{0, 8'h50, 8'h00, 3'h0, 1, 8'h90, 4'h0},
    '{1, 8'h60, 8'ha5, 3'h0, 1, 8'h00, 4'h5},
    '{0, 8'h60, 8'h00, 3'h0, 1, 8'ha5, 4'h0},
    '{0, 8'h60, 8'h00, 3'h2, 1, 8'ha5, 4'h0},
    '{0, 8'h60, 8'h00, 3'h3, 1, 8'h60, 4'h0},
    '{1, 8'h20, 8'h11, 3'h0, 1, 8'h00, 4'h0},
    '{1, 8'h4d, 8'h11, 3'h0, 1, 8'h00, 4'h5},
    '{1, 8'h7f, 8'h11, 3'h0, 1, 8'h00, 4'h5},
    '{1, 8'h80, 8'h11, 3'h0, 1, 8'h00, 4'h0},
    '{1, 8'hcf, 8'h11, 3'h0, 1, 8'h00, 4'h0},
    '{1, 8'hd0, 8'h11, 3'h0, 1, 8'h00, 4'h5},
    '{1, 8'hdf, 8'h11, 3'h0, 1, 8'h00, 4'h5},
    '{1, 8'he0, 8'h11, 3'h0, 1, 8'h00, 4'h0},
    '{0, 8'h4d, 8'h00, 3'h3, 1, 8'h4d, 4'h0},
    '{0, 8'h4d, 8'h00, 3'h0, 1, 8'h91, 4'h0},
    '{0, 8'h4b, 8'h00, 3'h0, 1, 8'h12, 4'h0},
    '{1, 8'h4a, 8'hff, 3'h0, 1, 8'h00, 4'h0},
    '{0, 8'h4a, 8'h00, 3'h0, 1, 8'h10, 4'h0},
    '{0, 8'h4a, 8'h00, 3'h3, 1, 8'h00, 4'h0},
    '{1, 8'h4b, 8'h81, 3'h0, 1, 8'h00, 4'h0},
    '{0, 8'h4b, 8'h00, 3'h2, 1, 8'h81, 4'h0},
    '{0, 8'h4b, 8'h00, 3'h3, 1, 8'h12, 4'h0},
    '{1, 8'h4c, 8'h0f, 3'h6, 0, 8'h00, 4'h0},
    '{0, 8'h4c, 8'h00, 3'h7, 0, 8'h00, 4'h0},
    '{0, 8'h4c, 8'h00, 3'h0, 1, 8'h25, 4'h0}
  };

  rpps_page_regs rpps_page_regs_i (.core_clk_in(core_clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
    .req_in(req_in), .paged_rd_data_in(paged_rd_data_in), .enc_crc_err_in(enc_crc_err_in),
    .csi2_mode_in(csi2_mode_in), .frame_start_in(frame_start_in), .long_pkt_in(long_pkt_in),
    .raw_type_in(raw_type_in), .ack_out(ack_out), .rd_data_out(rd_data_out),
    .paged_wr_en_out(paged_wr_en_out), .paged_addr_out(paged_addr_out), .paged_wdata_out(paged_wdata_out),
    .crc_flag_out(crc_flag_out), .dtype_out(dtype_out), .embedded_out(embedded_out));
  rpps_port_model rpps_port_model_i (.core_clk_in(core_clk_in), .wr_en_in(paged_wr_en_out),
    .wr_addr_in(paged_addr_out), .wr_data_in(paged_wdata_out), .rd_addr_in(req_in.addr),
    .rd_data_out(paged_rd_data_in));

  // 20 mhz clock
  initial begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // one access; an idle cycle after it keeps each strobe to one assignment per step
  task automatic acc(input rpps_row_t r);
    req_valid_in = 1'b1;
    req_in = '{write: r.w, addr: r.a, wdata: r.d, src: r.s};
    @(negedge core_clk_in);
    req_valid_in = 1'b0;
    `CHK("ack", r.k, ack_out)
    `CHK("strobes", r.we, paged_wr_en_out)
    if (!r.w && r.k) `CHK("read data", r.rd, rd_data_out)
    if (r.k) `CHK("address", r.a, paged_addr_out)
    if (r.k) `CHK("write data", r.d, paged_wdata_out)
    @(negedge core_clk_in);
  endtask

  // pulse frame start and long packet strobes for one cycle, then one idle cycle
  task automatic pkt(input logic [3:0] fs, input logic [3:0] lp);
    frame_start_in = fs;
    long_pkt_in = lp;
    @(negedge core_clk_in);
    frame_start_in = 4'h0;
    long_pkt_in = 4'h0;
    @(negedge core_clk_in);
  endtask

  // the whole run is under a hundred cycles; this is a generous ceiling
  initial begin
    #(2000 * 50);
    mismatches++;
    give_verdict();
  end

  initial begin
    rst_in = 1'b1;
    req_valid_in = 1'b0;
    req_in = '0;
    enc_crc_err_in = 4'h0;
    csi2_mode_in = 4'h4;
    frame_start_in = 4'h0;
    long_pkt_in = 4'h0;
    raw_type_in = {6'h00, 6'h2a, 6'h00, 6'h2b};
    repeat (6) @(negedge core_clk_in);
    rst_in = 1'b0;
    for (int i = 0; i < NROWS; i++) acc(rows[i]);
    $display("register rows done");
    // ports 0 and 2 hold two embedded lines of type 0x01; port 2 is in csi-2 mode
    pkt(4'h5, 4'h0);
    for (int i = 0; i < 3; i++) begin
      pkt(4'h0, 4'h5);
      `CHK("embedded 0", logic'(i < 2), embedded_out[0])
      `CHK("type 0", (i < 2) ? 6'h01 : 6'h2b, dtype_out[0])
      `CHK("embedded 2", 1'b0, embedded_out[2])
      `CHK("type 2", 6'h2a, dtype_out[2])
    end
    pkt(4'h5, 4'h0);
    pkt(4'h0, 4'h1);
    `CHK("new frame", 1'b1, embedded_out[0])
    $display("packet typing done");
    enc_crc_err_in = 4'hf; // encoder checks run: software has set the enable bit on ports 0 and 2
    @(negedge core_clk_in);
    `CHK("crc flags", 4'h5, crc_flag_out)
    $display("crc flag done");
    // reset in mid-run returns every source's page state and the port settings to their reset values
    rst_in = 1'b1;
    @(negedge core_clk_in);
    `CHK("reset flags", 4'h0, crc_flag_out)
    repeat (5) @(negedge core_clk_in);
    rst_in = 1'b0;
    acc('{0, 8'h4c, 8'h00, 3'h0, 1, 8'h00, 4'h0});
    acc('{0, 8'h4b, 8'h00, 3'h0, 1, 8'h12, 4'h0});
    `CHK("crc after reset", 4'h0, crc_flag_out)
    $display("reset done");
    give_verdict();
  end
endmodule // rx_port_page_select_tb_top
